/* sae_pkg.sv */
/*
  Package for the SDI audio embed control block: register offsets, field
  layouts, reset values, modes and timing constants.
  Assumes a single 200 MHz system clock and a plain register port.
*/
package sae_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_GROUPS     = 4;
  localparam int CH_PER_GROUP   = 4;
  localparam int NUM_CH         = 16;
  localparam int NUM_PAIRS      = 8;
  localparam int NUM_META       = 2;
  localparam int REDUCED_CH     = 8;
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;
  // ==========================================================
  // Timing
  localparam int  CLK_MHZ       = 200;
  localparam int  MS_CYCLES     = CLK_MHZ * 1000;
  localparam int  DELAY_MAX_MS  = 240;
  localparam int  VDELAY_MAX_FR = 15;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CARD     = 8'h00;
  localparam logic [7:0] REG_GROUPS   = 8'h04;
  localparam logic [7:0] REG_STATUS   = 8'h08;
  localparam logic [7:0] REG_META     = 8'h0c;
  localparam logic [7:0] REG_EMB_SRC  = 8'h10;
  localparam logic [7:0] REG_IN_MAP   = 8'h50;
  localparam logic [7:0] REG_OUT_MAP  = 8'h70;
  // ==========================================================
  // Card register fields
  localparam int F_RATE_CONV  = 0;
  localparam int F_VDLY_EN    = 1;
  localparam int F_GEN_LO     = 2;
  localparam int F_EMB_LO     = 4;
  localparam int F_DLY_DIR    = 6;
  localparam int F_REDUCED    = 7;
  localparam int F_DEEMB_ONLY = 8;
  localparam int F_VDLY_LO    = 12;
  localparam logic [DATA_W-1:0] CARD_RESET = 32'h0000_0001;
  // Per-pair map register fields
  localparam int F_GRP_LO   = 0;
  localparam int F_PAIR_SEL = 2;
  localparam int F_DLY_ON   = 3;
  localparam int F_WLEN_LO  = 4;
  localparam int F_DMS_LO   = 8;
  localparam int DMS_W      = 8;
  // ==========================================================
  // Modes
  typedef enum logic [1:0] {SAE_GEN_AUTO, SAE_GEN_FORCE, SAE_GEN_OFF} sae_gen_t;
  typedef enum logic [1:0] {SAE_EMB_OFF, SAE_EMB_ON, SAE_EMB_CLEAN} sae_emb_t;
  typedef enum logic [1:0] {SAE_WL_24, SAE_WL_20, SAE_WL_16} sae_wlen_t;
  localparam logic DIR_EMBED = 1'b0;
  localparam logic DIR_DEEMB = 1'b1;
endpackage

/* sae_ctrl.sv */
/*
  SDI audio embed control: configuration registers and the per-stream
  control decisions for embedder, de-embedder, generator, delays,
  dither and metadata ports.
  Assumes SDI lock and audio-present come from pins and are synchronised
  here; a software master on the plain register port.
*/
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
module sae_ctrl #(
  parameter int NUM_CH_P    = 16,
  parameter int MS_CYCLES_P = 200000
) (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        reset_n_in,
  // Register port
  input  wire logic [sae_pkg::ADDR_W-1:0]  reg_addr_in,
  input  wire logic [sae_pkg::DATA_W-1:0]  reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [sae_pkg::DATA_W-1:0]  reg_rdata_out,
  // SDI status pins
  input  wire logic                        sdi_lock_in,
  input  wire logic                        sdi_audio_in,
  input  wire logic [3:0]                  sdi_format_in,
  // Stream control
  output logic                             rate_convert_enable_out,
  output logic [15:0]                      rate_convert_ch_out,
  output logic [3:0]                       video_delay_frames_out,
  output logic                             receiver_enable_out,
  output logic                             generator_active_out,
  output logic [3:0]                       generator_format_out,
  output logic                             rate_from_generator_out,
  output logic                             deembed_enable_out,
  output logic                             embed_bypass_out,
  output logic                             embed_clean_out,
  output logic [3:0]                       group_replace_out,
  output logic [3:0]                       group_generate_out,
  output logic [63:0]                      embed_src_out,
  output logic [15:0]                      in_map_out,
  output logic [15:0]                      out_map_out,
  output logic [7:0]                       out_map_valid_out,
  output logic [7:0]                       in_delay_active_out,
  output logic [7:0]                       out_delay_active_out,
  output logic [7:0]                       delay_tick_out,
  output logic [7:0]                       dither_out,
  output logic [1:0]                       meta_embed_out,
  output logic [1:0]                       meta_deembed_out,
  output logic [1:0]                       meta_auto_out,
  output logic [21:0]                      meta_line_out
);
  import sae_pkg::*;

  initial begin
    if (NUM_CH_P != NUM_CH) $error("sae_ctrl serves sixteen channels only");
  end

  // ==========================================================
  // Pin synchronisers
  logic [5:0] sync1_q, sync2_q;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {sdi_format_in, sdi_audio_in, sdi_lock_in};
      sync2_q <= sync1_q;
    end
  end
  logic       lock_s, audio_s;
  logic [3:0] fmt_s;
  assign lock_s  = sync2_q[0];
  assign audio_s = sync2_q[1];
  assign fmt_s   = sync2_q[5:2];

  // ==========================================================
  // Registers
  logic [DATA_W-1:0] card_q, card_d;
  logic [3:0]        groups_q, groups_d;
  logic [31:0]       meta_q, meta_d;
  logic [3:0]        src_q [NUM_CH], src_d [NUM_CH];
  logic [15:0]       inm_q [NUM_PAIRS], inm_d [NUM_PAIRS];
  logic [15:0]       outm_q [NUM_PAIRS], outm_d [NUM_PAIRS];
  logic [3:0]        last_fmt_q, last_fmt_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  sae_gen_t gen_mode;
  sae_emb_t emb_mode;
  logic     reduced, deemb_only, dly_dir;
  assign gen_mode   = sae_gen_t'(card_q[F_GEN_LO +: 2]);
  assign emb_mode   = sae_emb_t'(card_q[F_EMB_LO +: 2]);
  assign dly_dir    = card_q[F_DLY_DIR];
  assign reduced    = card_q[F_REDUCED];
  assign deemb_only = card_q[F_DEEMB_ONLY];

  // Byte offset within each register array, counted from its base
  logic [7:0] src_off, inm_off, outm_off;
  assign src_off  = reg_addr_in - REG_EMB_SRC;
  assign inm_off  = reg_addr_in - REG_IN_MAP;
  assign outm_off = reg_addr_in - REG_OUT_MAP;

  always_comb begin
    card_d     = card_q;
    groups_d   = groups_q;
    meta_d     = meta_q;
    src_d      = src_q;
    inm_d      = inm_q;
    outm_d     = outm_q;
    rdata_d    = '0;
    // Hold last locked format for auto mode
    last_fmt_d = lock_s ? fmt_s : last_fmt_q;
    if (reg_wr_in) begin
      if (reg_addr_in == REG_CARD) card_d = reg_wdata_in;
      if (reg_addr_in == REG_GROUPS) groups_d = reg_wdata_in[3:0];
      if (reg_addr_in == REG_META) meta_d = reg_wdata_in;
      if (reg_addr_in >= REG_EMB_SRC && reg_addr_in < REG_IN_MAP)
        src_d[src_off[5:2]] = reg_wdata_in[3:0];
      if (reg_addr_in >= REG_IN_MAP && reg_addr_in < REG_OUT_MAP)
        inm_d[inm_off[4:2]] = reg_wdata_in[15:0];
      if (reg_addr_in >= REG_OUT_MAP && reg_addr_in < 8'h90)
        outm_d[outm_off[4:2]] = reg_wdata_in[15:0];
    end
    if (reg_rd_in) begin
      if (reg_addr_in == REG_CARD) rdata_d = card_q;
      else if (reg_addr_in == REG_GROUPS) rdata_d = {28'h0000000, groups_q};
      else if (reg_addr_in == REG_STATUS)
        rdata_d = {24'h000000, last_fmt_q, 2'b00, audio_s, lock_s};
      else if (reg_addr_in == REG_META) rdata_d = meta_q;
      else if (reg_addr_in >= REG_EMB_SRC && reg_addr_in < REG_IN_MAP)
        rdata_d = {28'h0000000, src_q[src_off[5:2]]};
      else if (reg_addr_in >= REG_IN_MAP && reg_addr_in < REG_OUT_MAP)
        rdata_d = {16'h0000, inm_q[inm_off[4:2]]};
      else if (reg_addr_in >= REG_OUT_MAP && reg_addr_in < 8'h90)
        rdata_d = {16'h0000, outm_q[outm_off[4:2]]};
    end
  end

  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      card_q     <= CARD_RESET;
      groups_q   <= 4'h0;
      meta_q     <= 32'h0000_0000;
      last_fmt_q <= 4'h0;
      rdata_q    <= 32'h0000_0000;
      for (int i = 0; i < NUM_CH; i++) src_q[i] <= 4'h0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
        inm_q[i]  <= 16'h0000;
        outm_q[i] <= 16'h0000;
      end
    end else begin
      card_q     <= card_d;
      groups_q   <= groups_d;
      meta_q     <= meta_d;
      last_fmt_q <= last_fmt_d;
      rdata_q    <= rdata_d;
      src_q      <= src_d;
      inm_q      <= inm_d;
      outm_q     <= outm_d;
    end
  end
  assign reg_rdata_out = rdata_q;

  // ==========================================================
  // Millisecond tick for pair delays
  logic [17:0] ms_cnt_q, ms_cnt_d;
  logic        ms_tick;
  assign ms_tick = (ms_cnt_q == 18'(MS_CYCLES_P - 1));
  always_comb begin
    ms_cnt_d = ms_tick ? 18'h00000 : ms_cnt_q + 18'h00001;
  end
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) ms_cnt_q <= 18'h00000;
    else ms_cnt_q <= ms_cnt_d;
  end

  // ==========================================================
  // Stream control outputs
  logic force_gen, bypass, emb_active;
  assign force_gen  = (gen_mode == SAE_GEN_FORCE);
  assign bypass     = deemb_only || (emb_mode == SAE_EMB_OFF);
  assign emb_active = !deemb_only && (emb_mode != SAE_EMB_OFF);

  logic [15:0] ch_mask;
  assign ch_mask = reduced ? 16'h00ff : 16'hffff;

  always_comb begin
    rate_convert_enable_out = card_q[F_RATE_CONV];
    rate_convert_ch_out     = card_q[F_RATE_CONV] ? ch_mask : 16'h0000;
    video_delay_frames_out  = card_q[F_VDLY_EN] ? card_q[F_VDLY_LO +: 4] : 4'h0;
    receiver_enable_out     = !force_gen;
    deembed_enable_out      = !force_gen;
    rate_from_generator_out = force_gen;
    generator_active_out    = force_gen || (gen_mode == SAE_GEN_AUTO && !lock_s);
    generator_format_out    = force_gen ? card_q[11:8] : last_fmt_q;
    embed_bypass_out        = bypass;
    embed_clean_out         = emb_active && (emb_mode == SAE_EMB_CLEAN);
    // Replace or generate each four-channel group
    for (int g = 0; g < NUM_GROUPS; g++) begin
      group_replace_out[g]  = !bypass && groups_q[g] && audio_s
                              && (emb_mode == SAE_EMB_ON);
      group_generate_out[g] = !bypass && groups_q[g]
                              && (!audio_s || emb_mode == SAE_EMB_CLEAN);
    end
    for (int c = 0; c < NUM_CH; c++) embed_src_out[c*4 +: 4] = src_q[c];
  end

  // Per pair mapping, delay and dither
  genvar p;
  generate
    for (p = 0; p < NUM_PAIRS; p++) begin : g_pair
      logic in_dly, out_dly;
      // Every pair delays in one direction only, chosen by the card's delay direction bit
      assign in_dly  = inm_q[p][F_DLY_ON] && dly_dir == DIR_DEEMB
                       && inm_q[p][F_DMS_LO +: DMS_W] <= 8'(DELAY_MAX_MS);
      assign out_dly = outm_q[p][F_DLY_ON] && dly_dir == DIR_EMBED;
      assign in_map_out[p*2 +: 2]  = inm_q[p][F_GRP_LO +: 2];
      assign out_map_out[p*2 +: 2] = outm_q[p][F_GRP_LO +: 2];
      assign out_map_valid_out[p]  = emb_active;
      assign in_delay_active_out[p]  = in_dly;
      assign out_delay_active_out[p] = out_dly;
      assign delay_tick_out[p] = ms_tick && (in_dly || out_dly);
      assign dither_out[p] = (outm_q[p][F_WLEN_LO +: 2] == SAE_WL_20)
                             || (outm_q[p][F_WLEN_LO +: 2] == SAE_WL_16);
    end
  endgenerate

  // Metadata ports
  generate
    for (p = 0; p < NUM_META; p++) begin : g_meta
      assign meta_embed_out[p]    = meta_q[p*16];
      assign meta_deembed_out[p]  = meta_q[p*16 + 1];
      assign meta_auto_out[p]     = meta_q[p*16 + 2];
      assign meta_line_out[p*11 +: 11] = meta_q[p*16 + 3 +: 11];
    end
  endgenerate

  // ==========================================================
  // Checks
  force_rx_off_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    force_gen |-> !receiver_enable_out && !deembed_enable_out)
    else $error("receiver on in forced mode");
  bypass_grp_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    deemb_only |-> group_replace_out == 4'h0 && group_generate_out == 4'h0)
    else $error("group active in bypass");
  rc_all_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    rate_convert_enable_out |-> rate_convert_ch_out == ch_mask)
    else $error("rate conversion on subset");
  reduced_ch_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    reduced |-> rate_convert_ch_out[15:8] == 8'h00)
    else $error("reduced card above eight channels");
  one_dir_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    (in_delay_active_out & out_delay_active_out) == 8'h00)
    else $error("delay both directions");
  hold_fmt_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !lock_s |=> last_fmt_q == $past(last_fmt_q))
    else $error("format not held");
  map_valid_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    emb_mode == SAE_EMB_OFF |-> out_map_valid_out == 8'h00)
    else $error("mapping active while off");
  no_audio_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    !audio_s |-> group_replace_out == 4'h0)
    else $error("replace without audio");
  read_lat_a: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
    reg_rd_in && reg_addr_in == REG_CARD |=> reg_rdata_out == $past(card_q))
    else $error("card read wrong");
endmodule

/* sae_sdi_model.sv */
/*
  Far-side SDI source model: drives the lock, audio-present and format pins.
  Assumes the bench requests pin states on the system clock.
*/
`timescale 1ns/10ps
module sae_sdi_model (
  // Requests from the bench
  input  wire logic       clk_in,
  input  wire logic       lock_req_in,
  input  wire logic       audio_req_in,
  input  wire logic [3:0] fmt_req_in,
  // SDI status pins
  output logic            lock_out,
  output logic            audio_out,
  output logic [3:0]      fmt_out
);
  // ==========================================================
  // Pins; format means nothing while unlocked, so it churns
  always_ff @(posedge clk_in) begin
    lock_out  <= lock_req_in;
    audio_out <= audio_req_in & lock_req_in;
    fmt_out   <= lock_req_in ? fmt_req_in : ~fmt_out;
  end
endmodule

/* tb_top.sv */
/*
  Self-checking bench for the SDI audio embed control block.
  Assumes the package, the control block and the SDI source model.
*/
`timescale 1ns/10ps
module tb_top;
  import sae_pkg::*;
  logic        clk_sys_in, reset_n_in, reg_wr_in, reg_rd_in, sdi_lock_in, sdi_audio_in;
  logic        lock_req, audio_req, rate_convert_enable_out, receiver_enable_out;
  logic        generator_active_out, rate_from_generator_out, deembed_enable_out;
  logic        embed_bypass_out, embed_clean_out;
  logic [3:0]  fmt_req, sdi_format_in, video_delay_frames_out, generator_format_out;
  logic [3:0]  group_replace_out, group_generate_out;
  logic [7:0]  reg_addr_in, out_map_valid_out, in_delay_active_out, out_delay_active_out;
  logic [7:0]  delay_tick_out, dither_out;
  logic [15:0] rate_convert_ch_out, in_map_out, out_map_out;
  logic [1:0]  meta_embed_out, meta_deembed_out, meta_auto_out;
  logic [21:0] meta_line_out;
  logic [31:0] reg_wdata_in, reg_rdata_out;
  logic [63:0] embed_src_out;
  int          miscompares, num_checks, cycles;

  sae_ctrl #(.NUM_CH_P(16), .MS_CYCLES_P(10)) i_sae_ctrl (.clk_sys_in, .reset_n_in,
    .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .sdi_lock_in,
    .sdi_audio_in, .sdi_format_in, .rate_convert_enable_out, .rate_convert_ch_out,
    .video_delay_frames_out, .receiver_enable_out, .generator_active_out,
    .generator_format_out, .rate_from_generator_out, .deembed_enable_out, .embed_bypass_out,
    .embed_clean_out, .group_replace_out, .group_generate_out, .embed_src_out, .in_map_out,
    .out_map_out, .out_map_valid_out, .in_delay_active_out, .out_delay_active_out,
    .delay_tick_out, .dither_out, .meta_embed_out, .meta_deembed_out, .meta_auto_out,
    .meta_line_out);
  sae_sdi_model i_sae_sdi_model (.clk_in(clk_sys_in), .lock_req_in(lock_req),
    .audio_req_in(audio_req), .fmt_req_in(fmt_req), .lock_out(sdi_lock_in),
    .audio_out(sdi_audio_in), .fmt_out(sdi_format_in));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    settle(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask
  task automatic pins(input logic l, input logic a, input logic [3:0] f);
    @(posedge clk_sys_in);
    lock_req  <= l;
    audio_req <= a;
    fmt_req   <= f;
    settle(8);
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_card();
    logic [31:0] d;
    rd(REG_CARD, d);
    chk(d, CARD_RESET);
    chk({rate_convert_enable_out, rate_convert_ch_out}, 17'h1ffff);
    rd(8'hfc, d);
    chk(d, 32'h0);
    wr(REG_CARD, 32'h81);
    chk(rate_convert_ch_out, 16'h00ff);
    wr(REG_CARD, 32'h0);
    chk(rate_convert_ch_out, 16'h0);
    wr(REG_CARD, 32'h7003);
    chk(video_delay_frames_out, 4'h7);
    wr(REG_CARD, 32'h7001);
    chk(video_delay_frames_out, 4'h0);
    $display("t_card done");
  endtask
  task automatic t_gen();
    pins(1'b1, 1'b1, 4'h5);
    chk(generator_format_out, 4'h5);
    pins(1'b0, 1'b1, 4'h5);
    chk(generator_format_out, 4'h5);
    pins(1'b1, 1'b1, 4'h5);
    wr(REG_CARD, 32'h5);
    chk({generator_active_out, receiver_enable_out, rate_from_generator_out,
         deembed_enable_out}, 4'b1010);
    $display("t_gen done");
  endtask
  task automatic t_embed();
    wr(REG_GROUPS, 32'ha);
    wr(REG_CARD, 32'h11);
    chk({group_replace_out, group_generate_out}, 8'ha0);
    pins(1'b1, 1'b0, 4'h5);
    chk({group_replace_out, group_generate_out}, 8'h0a);
    pins(1'b1, 1'b1, 4'h5);
    wr(REG_CARD, 32'h21);
    chk({embed_clean_out, group_generate_out}, 5'h1a);
    wr(REG_CARD, 32'h01);
    chk({group_replace_out, group_generate_out}, 8'h00);
    wr(REG_CARD, 32'h111);
    chk({embed_bypass_out, group_replace_out, group_generate_out}, 9'h100);
    wr(REG_GROUPS, 32'hf);
    wr(REG_CARD, 32'h11);
    chk(group_replace_out, 4'hf);
    $display("t_embed done");
  endtask
  task automatic t_delay();
    int n;
    wr(REG_IN_MAP, 32'h0508);
    wr(REG_OUT_MAP, 32'h0508);
    wr(REG_CARD, 32'h41);
    chk({in_delay_active_out[0], out_delay_active_out[0]}, 2'b10);
    n = 0;
    repeat (50) begin
      @(posedge clk_sys_in);
      #1;
      n += int'(delay_tick_out[0] === 1'b1);
    end
    chk(n, 5);
    wr(REG_IN_MAP, 32'hf008);
    chk(in_delay_active_out[0], 1'b1);
    wr(REG_CARD, 32'h01);
    chk({in_delay_active_out[0], out_delay_active_out[0]}, 2'b01);
    wr(REG_OUT_MAP, 32'h0500);
    chk(out_delay_active_out[0], 1'b0);
    $display("t_delay done");
  endtask
  task automatic t_map();
    wr(REG_IN_MAP + 8'h04, 32'h6);
    chk(in_map_out[3:2], 2'h2);
    wr(REG_OUT_MAP + 8'h1c, 32'h3);
    chk({out_map_valid_out[7], out_map_out[15:14]}, 3'b011);
    wr(REG_CARD, 32'h21);
    chk(out_map_valid_out[7], 1'b1);
    for (int w = 0; w < 3; w++) begin
      wr(REG_OUT_MAP, 32'(w) << 4);
      chk(dither_out[0], w != 0);
    end
    wr(REG_EMB_SRC + 8'h3c, 32'h9);
    wr(REG_EMB_SRC, 32'h3);
    chk({embed_src_out[63:60], embed_src_out[3:0]}, 8'h93);
    wr(REG_META, 32'h0006_091b);
    chk({meta_embed_out, meta_deembed_out, meta_auto_out}, 6'b011110);
    chk(meta_line_out[10:0], 11'h123);
    $display("t_map done");
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
    {lock_req, audio_req, fmt_req} = {1'b1, 1'b1, 4'h3};
    repeat (16) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    t_card();
    t_gen();
    t_embed();
    t_delay();
    t_map();
    results();
  end
endmodule
